// ===== design/cec_pkg.sv
// Purpose: shared constants for the camera event counter bank
// Assumes: one camera clock domain, registers on a plain strobe port
// Notes:   offsets are word indices on the register port
package cec_pkg;

  // ==========================================================================
  // sizes
  localparam int unsigned NUM_COUNTERS = 6;
  localparam int unsigned CNT_WIDTH    = 32;
  localparam int unsigned ADDR_WIDTH   = 4;
  localparam int unsigned SEL_WIDTH    = 3;

  // ==========================================================================
  // register offsets
  localparam logic [3:0] OFS_CHOICE    = 4'h0;
  localparam logic [3:0] OFS_SOURCE    = 4'h1;
  localparam logic [3:0] OFS_EDGE      = 4'h2;
  localparam logic [3:0] OFS_COMMAND   = 4'h3;
  localparam logic [3:0] OFS_READING   = 4'h4;
  localparam logic [3:0] OFS_CONDITION = 4'h5;
  localparam logic [3:0] OFS_CLEAR_SIG = 4'h6;

  // ==========================================================================
  // field positions
  localparam int unsigned CMD_CLEAR_BIT    = 0;
  localparam int unsigned CMD_SNAPSHOT_BIT = 1;
  localparam int unsigned COND_ACTIVE_BIT  = 0;
  localparam int unsigned COND_WRAPPED_BIT = 1;
  localparam int unsigned CLRSIG_EN_BIT    = 0;

  // ==========================================================================
  // encodings and reset values
  localparam logic [1:0] SOURCE_OFF   = 2'h0;
  localparam logic [1:0] SOURCE_FIXED = 2'h1;
  localparam logic       EDGE_RISING  = 1'b0;
  localparam logic       EDGE_FALLING = 1'b1;
  localparam logic [2:0] CHOICE_RST   = 3'h0;
  localparam logic [31:0] COUNT_RST   = 32'h0000_0000;

  // counting polarity of each counter, index 5 counts falling edges
  localparam logic [5:0] EDGE_MAP = 6'h20;

endpackage : cec_pkg

// ===== design/cec_event_counters.sv
// Purpose: bank of six fixed-source event counters with snapshot readout
// Assumes: sources and strobes synchronous to sys_clk, read data one cycle late
// Notes:   all state in one packed struct, one comb and one ff process
//
// Functional notes
// - counters 0-4 count rising source edges
// - counter 5 counts falling frame-send-done
// - counters only, no timer function
// - choice selects counter for all controls except the clear-signal enable, which is one bit for the bank
// - disabled after reset, enabled by source
// - read-only edge polarity of chosen counter
// - clear by command or clear signal
// - snapshot updates chosen reading; clear chosen
// - reading and condition follow chosen counter
// - enabled counter increments once per edge
//
// Strobed register access and the address map were chosen for this implementation.
`timescale 1ns/100ps

module cec_event_counters #(
  parameter int unsigned NUM = cec_pkg::NUM_COUNTERS,
  parameter int unsigned CW  = cec_pkg::CNT_WIDTH
) (
  input  wire logic                            sys_clk,
  input  wire logic                            rst_n,
  // internal timing sources
  input  wire logic                            lineFireEvent,
  input  wire logic                            lineStart,
  input  wire logic                            exposureStart,
  input  wire logic                            frameTrigger,
  input  wire logic                            frameStart,
  input  wire logic                            frameSendDone,
  // external clear signal
  input  wire logic                            countClearSignal,
  // register port
  input  wire logic [cec_pkg::ADDR_WIDTH-1:0]  regAddr,
  input  wire logic [31:0]                     regWrData,
  input  wire logic                            regWr,
  input  wire logic                            regRd,
  output logic      [31:0]                     regRdData
);
  import cec_pkg::*;

  // ==========================================================================
  // state
  typedef struct packed {
    logic [NUM-1:0]        srcPrev;
    logic [NUM-1:0][1:0]   srcPick;
    logic [NUM-1:0][CW-1:0] count;
    logic [NUM-1:0][CW-1:0] reading;
    logic [NUM-1:0]        wrapped;
    logic [SEL_WIDTH-1:0]  choice;
    logic                  clrSigEn;
    logic                  clrSigPrev;
    logic [31:0]           rdData;
  } cec_state_t;

  cec_state_t st_r;
  cec_state_t st_nxt;

  logic [NUM-1:0] srcNow;
  logic [NUM-1:0] edgeHit;
  logic           chosenOk;
  logic           wrChoice;
  logic           wrSource;
  logic           wrCommand;
  logic           wrClrSig;
  logic           cmdClear;
  logic           cmdSnap;
  logic           sigClear;

  // address match helper, used for every decode
  function automatic logic hitAt(input logic [ADDR_WIDTH-1:0] a,
                                 input logic [3:0] ofs);
    hitAt = (a == ofs);
  endfunction : hitAt

  // ==========================================================================
  // source gathering
  assign srcNow = {frameSendDone, frameStart, frameTrigger,
                   exposureStart, lineStart, lineFireEvent};

  genvar gi;
  generate
    for (gi = 0; gi < NUM; gi++) begin : g_edge
      assign edgeHit[gi] = EDGE_MAP[gi] ? (st_r.srcPrev[gi] & ~srcNow[gi])
                                        : (~st_r.srcPrev[gi] & srcNow[gi]);
    end
  endgenerate

  // ==========================================================================
  // write decode
  assign chosenOk  = (st_r.choice < SEL_WIDTH'(NUM));
  assign wrChoice  = regWr && hitAt(regAddr, OFS_CHOICE);
  assign wrSource  = regWr && hitAt(regAddr, OFS_SOURCE);
  assign wrCommand = regWr && hitAt(regAddr, OFS_COMMAND);
  assign wrClrSig  = regWr && hitAt(regAddr, OFS_CLEAR_SIG);
  assign cmdClear  = wrCommand && regWrData[CMD_CLEAR_BIT];
  assign cmdSnap   = wrCommand && regWrData[CMD_SNAPSHOT_BIT];
  // rising edge of the clear signal while enabled
  assign sigClear  = st_r.clrSigEn && countClearSignal && !st_r.clrSigPrev;

  // ==========================================================================
  // next state
  always_comb begin
    st_nxt            = st_r;
    st_nxt.srcPrev    = srcNow;
    st_nxt.clrSigPrev = countClearSignal;

    if (wrChoice) begin
      st_nxt.choice = regWrData[SEL_WIDTH-1:0];
    end
    if (wrClrSig) begin
      st_nxt.clrSigEn = regWrData[CLRSIG_EN_BIT];
    end

    if (wrSource && chosenOk) begin
      st_nxt.srcPick[st_r.choice] = (regWrData[1:0] == SOURCE_FIXED) ? SOURCE_FIXED
                                                                     : SOURCE_OFF;
    end

    for (int i = 0; i < NUM; i++) begin
      if (st_r.srcPick[i] == SOURCE_FIXED && edgeHit[i]) begin
        st_nxt.count[i] = st_r.count[i] + CW'(1);
        if (st_r.count[i] == {CW{1'b1}}) begin
          st_nxt.wrapped[i] = 1'b1;
        end
      end
    end

    if (chosenOk) begin
      if (cmdSnap) begin
        st_nxt.reading[st_r.choice] = st_r.count[st_r.choice];
      end
      if (cmdClear || sigClear) begin
        st_nxt.count[st_r.choice]   = COUNT_RST;
        st_nxt.wrapped[st_r.choice] = 1'b0;
      end
    end

    st_nxt.rdData = 32'h0000_0000;
    if (regRd) begin
      if (hitAt(regAddr, OFS_CHOICE)) begin
        st_nxt.rdData = 32'(st_r.choice);
      end else if (hitAt(regAddr, OFS_SOURCE) && chosenOk) begin
        st_nxt.rdData = 32'(st_r.srcPick[st_r.choice]);
      end else if (hitAt(regAddr, OFS_EDGE) && chosenOk) begin
        st_nxt.rdData = 32'(EDGE_MAP[st_r.choice]);
      end else if (hitAt(regAddr, OFS_READING) && chosenOk) begin
        st_nxt.rdData = 32'(st_r.reading[st_r.choice]);
      end else if (hitAt(regAddr, OFS_CONDITION) && chosenOk) begin
        st_nxt.rdData[COND_ACTIVE_BIT]  = (st_r.srcPick[st_r.choice] == SOURCE_FIXED);
        st_nxt.rdData[COND_WRAPPED_BIT] = st_r.wrapped[st_r.choice];
      end else if (hitAt(regAddr, OFS_CLEAR_SIG)) begin
        st_nxt.rdData = 32'(st_r.clrSigEn);
      end
    end
  end

  // ==========================================================================
  // state register, synchronous reset
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st_r         <= '0;
      st_r.choice  <= CHOICE_RST;
      st_r.srcPrev <= '0;         // edge history clear: sources idle low
    end else begin
      st_r <= st_nxt;
    end
  end

  assign regRdData = st_r.rdData;

endmodule : cec_event_counters

// ===== test/cec_monitor.sv
// Purpose: port checks for the event counter bank
// Assumes: one clock, read data one cycle after the strobe
// Notes:   mirrors the chosen counter from register writes
`timescale 1ns/100ps
module cec_monitor
  import cec_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        countClearSignal,
  input wire logic [3:0]  regAddr,
  input wire logic [31:0] regWrData,
  input wire logic        regWr,
  input wire logic        regRd,
  input wire logic [31:0] regRdData
);
  logic [2:0] choice_r;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // follow the chosen counter
  always_ff @(posedge sys_clk) begin
    if (!rst_n) choice_r <= CHOICE_RST;
    else if (regWr && regAddr == OFS_CHOICE) choice_r <= regWrData[2:0];
  end
  property p_idle; !regRd |=> regRdData == '0; endproperty
  property p_edge; regRd && regAddr == OFS_EDGE |=>
    regRdData == ((choice_r < 3'h6) ? {31'h0, EDGE_MAP[choice_r]} : '0); endproperty
  property p_choice; regRd && regAddr == OFS_CHOICE |=> regRdData == {29'h0, choice_r}; endproperty
  property p_unmap; regRd && regAddr > OFS_CLEAR_SIG |=> regRdData == '0; endproperty
  property p_cmd; regRd && regAddr == OFS_COMMAND |=> regRdData == '0; endproperty
  property p_src; regRd && regAddr == OFS_SOURCE |=> regRdData[31:1] == '0; endproperty
  property p_cond; regRd && regAddr == OFS_CONDITION |=> regRdData[31:2] == '0; endproperty
  property p_clr; regRd && regAddr == OFS_CLEAR_SIG |=> regRdData[31:1] == '0; endproperty
  a_idle: assert property (p_idle) else $error("read data not idle");
  a_edge: assert property (p_edge) else $error("edge polarity wrong");
  a_choice: assert property (p_choice) else $error("choice readback wrong");
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  a_cmd: assert property (p_cmd) else $error("command read not zero");
  a_src: assert property (p_src) else $error("source field too wide");
  a_cond: assert property (p_cond) else $error("condition field too wide");
  a_clr: assert property (p_clr) else $error("clear enable too wide");
  c_cmd: cover property (regWr && regAddr == OFS_COMMAND);
  c_read: cover property (regRd && regAddr == OFS_READING);
  c_clr: cover property ($rose(countClearSignal));
endmodule : cec_monitor

// ===== test/cec_event_counters_tb_top.sv
// Purpose: self-checking bench for the event counter bank
// Assumes: 100 MHz clock, synchronous active-low reset
// Notes:   counts are checked through snapshot reads
`timescale 1ns/100ps
module cec_event_counters_tb_top;
  import cec_pkg::*;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [6:0]  src = '0;
  logic [3:0]  regAddr = '0;
  logic [31:0] regWrData = '0;
  logic        regWr = 1'b0;
  logic        regRd = 1'b0;
  logic [31:0] regRdData;
  int          numErrors = 0;
  int          compares = 0;
  // device, sources and clear from the pulse vector
  cec_event_counters i_dut (.lineFireEvent(src[0]), .lineStart(src[1]),
    .exposureStart(src[2]), .frameTrigger(src[3]), .frameStart(src[4]),
    .frameSendDone(src[5]), .countClearSignal(src[6]), .*);
  always #5 sys_clk = ~sys_clk;
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
    @(posedge sys_clk);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1;
    compares++;
    if (regRdData !== e) begin
      numErrors++;
      $display("BAD %0t got %h exp %h", $time, regRdData, e);
    end
    @(posedge sys_clk);
  endtask : rd
  task automatic pulse(input int i, input int n);
    repeat (n) begin
      src[i] <= 1'b1;
      @(posedge sys_clk);
      src[i] <= 1'b0;
      @(posedge sys_clk);
    end
    @(posedge sys_clk);
  endtask : pulse
  // choose, snapshot, read the count
  task automatic chk(input int i, input logic [31:0] e);
    wr(OFS_CHOICE, 32'(i));
    wr(OFS_COMMAND, 32'h0000_0002);
    rd(OFS_READING, e);
  endtask : chk
  task automatic finish_test;
    $display("errors %0d compares %0d", numErrors, compares);
    if (numErrors == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finish_test
  // watchdog
  initial begin
    #100us;
    numErrors++;
    finish_test();
  end
  initial begin
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rd(OFS_CLEAR_SIG, 32'h0);
    for (int i = 0; i < 6; i++) begin
      wr(OFS_CHOICE, 32'(i));
      rd(OFS_SOURCE, 32'(SOURCE_OFF));
      rd(OFS_EDGE, 32'(i == 5));
      pulse(i, 1);
      chk(i, 32'h0);
      wr(OFS_SOURCE, 32'(SOURCE_FIXED));
      rd(OFS_CONDITION, 32'h1);
    end
    for (int i = 0; i < 6; i++) pulse(i, i + 1);
    for (int i = 0; i < 6; i++) chk(i, 32'(i + 1));
    wr(OFS_COMMAND, 32'h0000_0001);
    rd(OFS_READING, 32'h6);
    chk(5, 32'h0);
    chk(2, 32'h3);
    wr(OFS_COMMAND, 32'h0000_0001);
    chk(2, 32'h0);
    chk(3, 32'h4);
    wr(OFS_CLEAR_SIG, 32'h0000_0001);
    pulse(6, 1);
    chk(3, 32'h0);
    chk(1, 32'h2);
    pulse(1, 1);
    rd(OFS_READING, 32'h2);
    chk(1, 32'h3);
    wr(OFS_EDGE, 32'h0000_0001);
    rd(OFS_EDGE, 32'h0);
    rd(4'hF, 32'h0);
    finish_test();
  end
endmodule : cec_event_counters_tb_top
bind cec_event_counters cec_monitor i_mon (.*);
